// ---- rtl/cpu_bank_pkg.sv ----
// constants and carrier types for the cpu bank, register and stack addressing block
// Behaviour
// RULE1: interrupt vector gives bank enables and handler address
// RULE2: vector start address is fourteen bits wide
// RULE3: table call fetches from table region
// RULE4: pair branches replace only program counter low byte
// RULE5: ram holds 768 plus 160 display words; the display window decoded here is 96 words, 1a0..1ff
// RULE6: every bank 0..3 address usable for stack
// RULE7: software gives even address for byte access
// RULE8: display area also maps key scan and digit port
// RULE9: four banks of eight 4-bit registers
// RULE10: active bank is enable flag and select field
// RULE11: four pairs for bytes, three as pointers
// RULE12: register locations also reachable as plain ram
// RULE13: accumulator, wide pair, carry as bit accumulator
// RULE14: 8-bit stack pointer, 4-bit stack bank select
// RULE15: decrement before push, increment after pop
// RULE16: upper two stack bank bits read zero
// RULE17: software writes and reads both stack registers
// RULE18: stack bank codes pick banks 0 to 3
// RULE19: pointer zero pushes first to bank top
// RULE20: pointer wraps within bank, no crossing
// RULE21: stack registers undefined after reset, software initialises
// RULE22: calls save only the two bank enable flags
// RULE23: reset loads enables and start from first bytes
// RULE24: memory bank enable from vector bit 7
// RULE25: register bank enable from vector bit 6
// RULE26: enable clear forces register bank 0
// RULE27: vector load forces program counter top bit zero
package cpu_bank_pkg;
  localparam int unsigned PC_W = 15;
  localparam int unsigned RAM_AW = 10;
  localparam int unsigned RAM_WORDS = 1024;
  localparam logic [11:0] VEC_BASE = 12'h002;
  localparam logic [11:0] VEC_LAST = 12'h00f;
  localparam logic [11:0] RESET_VEC = 12'h000;
  localparam logic [11:0] TABLE_BASE = 12'h020;
  localparam logic [11:0] TABLE_LAST = 12'h07f;
  localparam int unsigned MBE_BIT = 7;
  localparam int unsigned RBE_BIT = 6;
  localparam logic [11:0] REG_AREA_BASE = 12'hee0;
  localparam logic [11:0] STACK_PTR_ADDR = 12'hf80;
  localparam logic [11:0] STACK_BANK_ADDR = 12'hf84;
  localparam logic [11:0] DISP_BASE = 12'h1a0;
  localparam logic [11:0] DISP_LAST = 12'h1ff;
  localparam logic [11:0] KEY_SCAN_2_ADDR = 12'h1be;
  localparam logic [11:0] KEY_SCAN_0_ADDR = 12'h1fc;
  localparam logic [11:0] KEY_SCAN_1_ADDR = 12'h1fe;
  localparam logic [11:0] DIGIT_PORT_ADDR = 12'h1ff;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [3:0] SBS_RESET = 4'h0;
  localparam logic [3:0] SBS_RSVD_MASK = 4'h3;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_VECTOR = 3'h1,
    OP_TABLE = 3'h2,
    OP_BR_DE = 3'h3,
    OP_BR_XA = 3'h4,
    OP_PUSH = 3'h5,
    OP_POP = 3'h6
  } cpu_op_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic wide;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    cpu_op_t op;
    logic [3:0] index;
    logic [7:0] vec_hi;
    logic [7:0] vec_lo;
    logic [7:0] push_data;
    logic call_ret;
  } cpu_cmd_t;
endpackage

// ---- rtl/data_ram.sv ----
// data memory: banks 0..3 of static ram with byte access on even addresses
`timescale 1ns/1ps
module data_ram (
  input wire logic mclk_in,
  input wire logic we_in,
  input wire logic wide_in,
  input wire logic [cpu_bank_pkg::RAM_AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  import cpu_bank_pkg::*;
  // bank 1 holds only the display window; other bank 1 cells are kept for simplicity
  logic [3:0] mem [0:RAM_WORDS-1]; // [RULE5] [RULE6]
  logic [RAM_AW-1:0] hi_addr;

  assign hi_addr = addr_in | {{(RAM_AW-1){1'b0}}, 1'b1};

  always_ff @(posedge mclk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in[3:0];
      if (wide_in) begin
        mem[hi_addr] <= wdata_in[7:4]; // [RULE7]
      end
    end
  end

  always_comb begin
    rdata_out = {wide_in ? mem[hi_addr] : 4'h0, mem[addr_in]};
  end
endmodule

// ---- rtl/stack_ctrl.sv ----
// stack pointer and stack bank select with pre-decrement push and post-increment pop
`timescale 1ns/1ps
module stack_ctrl (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic sp_wr_in,
  input wire logic sbs_wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] sp_out,
  output logic [3:0] sbs_out,
  output logic [9:0] push_addr_out,
  output logic [9:0] pop_addr_out
);
  import cpu_bank_pkg::*;
  logic [7:0] stack_pointer_ff;
  logic [3:0] stack_bank_select_ff;
  logic [7:0] nxt_stack_pointer;

  // reset value is only for a clean simulation; software must still set it
  always_comb begin
    nxt_stack_pointer = stack_pointer_ff;
    if (sp_wr_in) begin
      nxt_stack_pointer = wdata_in; // [RULE17] [RULE21]
    end else if (push_in) begin
      nxt_stack_pointer = stack_pointer_ff - 8'h01; // [RULE15] [RULE20]
    end else if (pop_in) begin
      nxt_stack_pointer = stack_pointer_ff + 8'h01; // [RULE15]
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stack_pointer_ff <= SP_RESET;
    end else begin
      stack_pointer_ff <= nxt_stack_pointer;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stack_bank_select_ff <= SBS_RESET;
    end else if (sbs_wr_in) begin
      stack_bank_select_ff <= wdata_in[3:0] & SBS_RSVD_MASK; // [RULE16] [RULE17]
    end
  end

  assign sp_out = stack_pointer_ff;
  assign sbs_out = stack_bank_select_ff;
  // bank from the two low select bits; pointer wraps inside that bank
  assign push_addr_out = {stack_bank_select_ff[1:0], stack_pointer_ff - 8'h01}; // [RULE18] [RULE19]
  assign pop_addr_out = {stack_bank_select_ff[1:0], stack_pointer_ff}; // [RULE14]

  stack_wrap_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE20]
    (push_in && !sp_wr_in && stack_pointer_ff == 8'h00) |=> stack_pointer_ff == 8'hff)
    else $error("stack pointer did not wrap to bank top");
  pop_incr_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE15]
    (pop_in && !push_in && !sp_wr_in) |=> stack_pointer_ff == $past(stack_pointer_ff) + 8'h01)
    else $error("pop did not increment stack pointer");
  sbs_upper_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE16]
    stack_bank_select_ff[3:2] == 2'b00)
    else $error("stack bank upper bits not zero");
  sp_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE17]
    sp_wr_in |=> stack_pointer_ff == $past(wdata_in))
    else $error("stack pointer write lost");
  push_cov_c: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
    push_in && stack_pointer_ff == 8'h00);
endmodule

// ---- rtl/cpu_bank_core.sv ----
// cpu addressing core: vectors, table call, low-byte branches, register banks and stack
`timescale 1ns/1ps
module cpu_bank_core (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire cpu_bank_pkg::cpu_cmd_t cmd_in,
  input wire cpu_bank_pkg::mem_req_t mem_req_in,
  input wire logic [1:0] reg_bank_select_field_in,
  input wire logic [7:0] rom_reset_hi_in,
  input wire logic [7:0] rom_reset_lo_in,
  output logic [cpu_bank_pkg::PC_W-1:0] program_counter_out,
  output logic [11:0] rom_fetch_addr_out,
  output logic mem_bank_expand_flag_out,
  output logic reg_bank_expand_flag_out,
  output logic [1:0] active_reg_bank_out,
  output logic [7:0] mem_rdata_out,
  output logic [7:0] stack_pointer_out,
  output logic [3:0] stack_bank_select_out,
  output logic [7:0] pop_data_out,
  output logic display_hit_out,
  output logic [1:0] key_scan_sel_out,
  output logic digit_port_hit_out
);
  import cpu_bank_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] reg_addr(input logic [1:0] bank, input logic [2:0] idx);
    reg_addr = RAM_AW'(REG_AREA_BASE[9:0] + {bank, idx});
  endfunction

  function automatic logic in_display(input logic [11:0] a);
    in_display = (a >= DISP_BASE) && (a <= DISP_LAST);
  endfunction

  logic [PC_W-1:0] program_counter_ff;
  logic mem_bank_expand_flag_ff;
  logic reg_bank_expand_flag_ff;
  logic [1:0] active_reg_bank_ff;
  logic [11:0] rom_fetch_addr_ff;
  logic [7:0] mem_rdata_ff;
  logic [7:0] pop_data_ff;
  logic display_hit_ff;
  logic [1:0] key_scan_sel_ff;
  logic digit_port_hit_ff;
  logic [7:0] de_pair;
  logic [7:0] xa_pair;
  logic [7:0] ram_rdata;
  logic [7:0] sp_val;
  logic [3:0] sbs_val;
  logic [9:0] push_addr;
  logic [9:0] pop_addr;
  logic [1:0] nxt_active_reg_bank;
  logic sp_wr;
  logic sbs_wr;
  logic push;
  logic pop;
  logic ram_we;
  logic ram_wide;
  logic [9:0] ram_addr;
  logic [7:0] ram_wdata;
  logic reset_load_ff;

  // ----------------------------------------------------------------
  // stack registers mapped into the peripheral area
  // ----------------------------------------------------------------
  assign push = (cmd_in.op == OP_PUSH);
  assign pop = (cmd_in.op == OP_POP);
  assign sp_wr = mem_req_in.wr && mem_req_in.wide && (mem_req_in.addr == STACK_PTR_ADDR); // [RULE17]
  assign sbs_wr = mem_req_in.wr && !mem_req_in.wide && (mem_req_in.addr == STACK_BANK_ADDR); // [RULE17]

  stack_ctrl u_stack (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(push),
    .pop_in(pop),
    .sp_wr_in(sp_wr),
    .sbs_wr_in(sbs_wr),
    .wdata_in(mem_req_in.wdata),
    .sp_out(sp_val),
    .sbs_out(sbs_val),
    .push_addr_out(push_addr),
    .pop_addr_out(pop_addr)
  );

  // ----------------------------------------------------------------
  // ram port: stack has priority over software access
  // ----------------------------------------------------------------
  always_comb begin
    ram_we = 1'b0;
    ram_wide = mem_req_in.wide;
    ram_addr = mem_req_in.addr[9:0];
    ram_wdata = mem_req_in.wdata;
    // peripheral addresses above bank 3 never write the ram cells; reads there, except the two stack registers, return the cell at addr[9:0]
    if (push) begin
      ram_we = 1'b1; // [RULE6]
      ram_wide = 1'b0;
      ram_addr = push_addr;
      // calls keep just the two enable flags; other status bits are not stacked
      ram_wdata = cmd_in.call_ret ? {6'h00, mem_bank_expand_flag_ff, reg_bank_expand_flag_ff} // [RULE22]
                                  : cmd_in.push_data;
    end else if (pop) begin
      ram_wide = 1'b0;
      ram_addr = pop_addr;
    end else if (mem_req_in.wr && (mem_req_in.addr[11:10] == 2'b00)) begin
      ram_we = 1'b1; // [RULE12] [RULE8]
    end
  end

  data_ram u_ram (
    .mclk_in(mclk_in),
    .we_in(ram_we),
    .wide_in(ram_wide),
    .addr_in(ram_addr),
    .wdata_in(ram_wdata),
    .rdata_out(ram_rdata)
  );

  // ----------------------------------------------------------------
  // register pairs taken from the command's vec_hi and vec_lo nibbles
  // ----------------------------------------------------------------
  // indices b=0 c=1 d=2 e=3 h=4 l=5 x=6 a=7; pairs occupy adjacent cells
  assign de_pair = {cmd_in.vec_hi[3:0], cmd_in.vec_lo[3:0]}; // [RULE11]
  assign xa_pair = {cmd_in.vec_hi[7:4], cmd_in.vec_lo[7:4]}; // [RULE13]

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // one-shot after release: the reset entry bytes are taken at the first edge only
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reset_load_ff <= 1'b1;
    end else begin
      reset_load_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      program_counter_ff <= '0;
    end else if (reset_load_ff) begin
      program_counter_ff <= {1'b0, rom_reset_hi_in[5:0], rom_reset_lo_in}; // [RULE23]
    end else begin
      case (cmd_in.op)
        OP_VECTOR: program_counter_ff <= {1'b0, cmd_in.vec_hi[5:0], cmd_in.vec_lo}; // [RULE1] [RULE2] [RULE27]
        OP_BR_DE: program_counter_ff <= {program_counter_ff[PC_W-1:8], de_pair}; // [RULE4]
        OP_BR_XA: program_counter_ff <= {program_counter_ff[PC_W-1:8], xa_pair}; // [RULE4]
        default: program_counter_ff <= program_counter_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // rom fetch address for vector and table entries
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rom_fetch_addr_ff <= RESET_VEC;
    end else begin
      case (cmd_in.op)
        // the index is not range checked; callers keep it inside the table
        OP_VECTOR: rom_fetch_addr_ff <= VEC_BASE + {7'h00, cmd_in.index[3:0], 1'b0}; // [RULE1]
        OP_TABLE: rom_fetch_addr_ff <= TABLE_BASE + {6'h00, cmd_in.index[3:0], 2'b00}; // [RULE3]
        default: rom_fetch_addr_ff <= rom_fetch_addr_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bank enable flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_bank_expand_flag_ff <= 1'b0;
      reg_bank_expand_flag_ff <= 1'b0;
    end else if (reset_load_ff) begin
      mem_bank_expand_flag_ff <= rom_reset_hi_in[MBE_BIT]; // [RULE23]
      reg_bank_expand_flag_ff <= rom_reset_hi_in[RBE_BIT]; // [RULE23]
    end else if (cmd_in.op == OP_VECTOR) begin
      mem_bank_expand_flag_ff <= cmd_in.vec_hi[MBE_BIT]; // [RULE24]
      reg_bank_expand_flag_ff <= cmd_in.vec_hi[RBE_BIT]; // [RULE25]
    end else if (pop && cmd_in.call_ret) begin
      mem_bank_expand_flag_ff <= ram_rdata[1]; // [RULE22]
      reg_bank_expand_flag_ff <= ram_rdata[0]; // [RULE22]
    end
  end

  // ----------------------------------------------------------------
  // active register bank
  // ----------------------------------------------------------------
  // registered: a new select value or enable shows one cycle later
  assign nxt_active_reg_bank = reg_bank_select_field_in & {2{reg_bank_expand_flag_ff}}; // [RULE10] [RULE26]

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      active_reg_bank_ff <= 2'b00;
    end else begin
      active_reg_bank_ff <= nxt_active_reg_bank; // [RULE9]
    end
  end

  // ----------------------------------------------------------------
  // read data, stack data and display decode
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_rdata_ff <= 8'h00;
      pop_data_ff <= 8'h00;
    end else begin
      if (mem_req_in.rd && mem_req_in.addr == STACK_PTR_ADDR) begin
        mem_rdata_ff <= sp_val; // [RULE17]
      end else if (mem_req_in.rd && mem_req_in.addr == STACK_BANK_ADDR) begin
        mem_rdata_ff <= {4'h0, sbs_val}; // [RULE17]
      end else if (mem_req_in.rd && !push && !pop) begin
        mem_rdata_ff <= ram_rdata; // [RULE12]
      end
      if (pop) begin
        pop_data_ff <= ram_rdata;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      display_hit_ff <= 1'b0;
      key_scan_sel_ff <= 2'b00;
      digit_port_hit_ff <= 1'b0;
    end else begin
      display_hit_ff <= mem_req_in.wr && in_display(mem_req_in.addr); // [RULE8]
      digit_port_hit_ff <= mem_req_in.wr && (mem_req_in.addr == DIGIT_PORT_ADDR);
      // key scan select follows any access to its address, reads as well
      case (mem_req_in.addr)
        KEY_SCAN_0_ADDR: key_scan_sel_ff <= 2'b01;
        KEY_SCAN_1_ADDR: key_scan_sel_ff <= 2'b10;
        KEY_SCAN_2_ADDR: key_scan_sel_ff <= 2'b11;
        default: key_scan_sel_ff <= 2'b00;
      endcase
    end
  end

  assign program_counter_out = program_counter_ff;
  assign rom_fetch_addr_out = rom_fetch_addr_ff;
  assign mem_bank_expand_flag_out = mem_bank_expand_flag_ff;
  assign reg_bank_expand_flag_out = reg_bank_expand_flag_ff;
  assign active_reg_bank_out = active_reg_bank_ff;
  assign mem_rdata_out = mem_rdata_ff;
  assign stack_pointer_out = sp_val;
  assign stack_bank_select_out = sbs_val;
  assign pop_data_out = pop_data_ff;
  assign display_hit_out = display_hit_ff;
  assign key_scan_sel_out = key_scan_sel_ff;
  assign digit_port_hit_out = digit_port_hit_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  vector_pc_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE27]
    (cmd_in.op == OP_VECTOR && !reset_load_ff) |=>
      program_counter_ff == {1'b0, $past(cmd_in.vec_hi[5:0]), $past(cmd_in.vec_lo)})
    else $error("vector handler address wrong");
  vector_flags_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE24] [RULE25]
    (cmd_in.op == OP_VECTOR && !reset_load_ff) |=>
      reg_bank_expand_flag_ff == $past(cmd_in.vec_hi[6]) && mem_bank_expand_flag_ff == $past(cmd_in.vec_hi[7]))
    else $error("vector bank enables wrong");
  branch_low_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE4]
    ((cmd_in.op == OP_BR_DE || cmd_in.op == OP_BR_XA) && !reset_load_ff) |=>
      program_counter_ff[14:8] == $past(program_counter_ff[14:8]))
    else $error("branch changed upper program counter");
  bank_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE26]
    !reg_bank_expand_flag_ff |=> active_reg_bank_ff == 2'b00)
    else $error("bank nonzero with enable clear");
  bank_and_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE10]
    reg_bank_expand_flag_ff |=> active_reg_bank_ff == $past(reg_bank_select_field_in))
    else $error("active bank not select field");
  pc_range_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE2]
    (cmd_in.op == OP_VECTOR) |=> program_counter_ff[14] == 1'b0)
    else $error("handler outside low space");

  // ----------------------------------------------------------------
  // checks on fetch, stack and display
  // ----------------------------------------------------------------
  vector_entry_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE1]
    (cmd_in.op == OP_VECTOR && cmd_in.index < 4'h7) |=>
      rom_fetch_addr_ff >= VEC_BASE && rom_fetch_addr_ff <= VEC_LAST && !rom_fetch_addr_ff[0])
    else $error("vector entry outside vector table");
  table_range_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE3]
    (cmd_in.op == OP_TABLE) |=> rom_fetch_addr_ff >= TABLE_BASE && rom_fetch_addr_ff <= TABLE_LAST)
    else $error("table fetch outside table area");
  stack_save_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE6]
    push |-> ram_we && !ram_wide && ram_addr == push_addr)
    else $error("stack save did not reach ram");
  digit_pulse_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE8]
    (mem_req_in.wr && mem_req_in.addr == DIGIT_PORT_ADDR) |=> display_hit_ff && digit_port_hit_ff)
    else $error("digit port write not inside display area");
  sbs_read_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [RULE17]
    (mem_req_in.rd && mem_req_in.addr == STACK_BANK_ADDR) |=> mem_rdata_ff == {4'h0, $past(sbs_val)})
    else $error("stack bank read back wrong");
  vector_cov_c: cover property (@(posedge mclk_in) disable iff (sys_rst_in) cmd_in.op == OP_VECTOR);
  call_cov_c: cover property (@(posedge mclk_in) disable iff (sys_rst_in) push && cmd_in.call_ret ##[1:8] pop && cmd_in.call_ret);
  branch_cov_c: cover property (@(posedge mclk_in) disable iff (sys_rst_in) cmd_in.op == OP_BR_XA);
  table_cov_c: cover property (@(posedge mclk_in) disable iff (sys_rst_in) cmd_in.op == OP_TABLE);
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the cpu bank, register and stack addressing core
`timescale 1ns/1ps
module tb_top;
  import cpu_bank_pkg::*;
  // ----------------------------------------
  // stimulus, observed outputs and model state
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  cpu_cmd_t cmd_in = '0;
  mem_req_t mem_req_in = '0;
  logic [1:0] reg_bank_select_field_in = 2'h0;
  logic [7:0] rom_reset_hi_in = 8'he5;
  logic [7:0] rom_reset_lo_in = 8'h3a;
  logic [14:0] pc_w;
  logic [11:0] fetch_w;
  logic mbe_w, rbe_w, disp_w, digit_w;
  logic [1:0] bank_w, ks_w;
  logic [7:0] rdata_w, sp_w, pop_w;
  logic [3:0] sbs_w;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int m_sp, m_sbs, m_pc, m_mbe, m_rbe;
  int ram [1024];
  int stk [$];
  logic [31:0] rng = 32'h3031;
  logic [7:0] r8;

  cpu_bank_core i_cpu_bank_core (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd_in), .mem_req_in(mem_req_in),
    .reg_bank_select_field_in(reg_bank_select_field_in), .rom_reset_hi_in(rom_reset_hi_in),
    .rom_reset_lo_in(rom_reset_lo_in), .program_counter_out(pc_w), .rom_fetch_addr_out(fetch_w),
    .mem_bank_expand_flag_out(mbe_w), .reg_bank_expand_flag_out(rbe_w), .active_reg_bank_out(bank_w),
    .mem_rdata_out(rdata_w), .stack_pointer_out(sp_w), .stack_bank_select_out(sbs_w),
    .pop_data_out(pop_w), .display_hit_out(disp_w), .key_scan_sel_out(ks_w), .digit_port_hit_out(digit_w)
  );

  always #5 mclk_in = ~mclk_in;

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  function automatic cpu_cmd_t mk(input cpu_op_t op, input logic [3:0] idx, input logic [7:0] hi, lo, pd,
                                  input logic cr);
    mk = '{op, idx, hi, lo, pd, cr};
  endfunction

  function automatic mem_req_t mkr(input logic wr, rd, wide, input logic [11:0] a, input logic [7:0] d);
    mkr = '{wr, rd, wide, a, d};
  endfunction

  // one request held for one sampling edge, then idle; results are read just after that edge
  task automatic issue(input cpu_cmd_t c, input mem_req_t r);
    @(posedge mclk_in);
    cmd_in <= c;
    mem_req_in <= r;
    @(posedge mclk_in);
    cmd_in <= '0;
    mem_req_in <= '0;
    #1;
  endtask

  task automatic wr_mem(input logic [11:0] a, input logic [7:0] d, input logic wide);
    issue('0, mkr(1'b1, 1'b0, wide, a, d));
    if (a[11:10] == 2'b00) begin
      ram[a[9:0]] = d[3:0];
      if (wide) begin
        ram[a[9:0] + 1] = d[7:4];
      end
    end
  endtask

  task automatic rd_mem(input logic [11:0] a, input logic wide);
    issue('0, mkr(1'b0, 1'b1, wide, a, 8'h00));
    if (wide) begin
      check(rdata_w, ram[a[9:0] + 1] * 16 + ram[a[9:0]], "byte read");
    end else begin
      check(rdata_w[3:0], ram[a[9:0]], "nibble read");
    end
  endtask

  task automatic vector(input logic [3:0] idx, input logic [7:0] hi, lo);
    issue(mk(OP_VECTOR, idx, hi, lo, 8'h00, 1'b0), '0);
    m_pc = hi[5:0] * 256 + lo;
    m_mbe = hi[MBE_BIT];
    m_rbe = hi[RBE_BIT];
    check(pc_w, m_pc, "vector start");
    check(mbe_w, m_mbe, "vector memory enable");
    check(rbe_w, m_rbe, "vector register enable");
    check(fetch_w, VEC_BASE + 2 * idx, "vector entry fetch");
  endtask

  task automatic push(input logic [7:0] d, input logic cr);
    int v;
    v = cr ? m_mbe * 2 + m_rbe : d[3:0];
    issue(mk(OP_PUSH, 4'h0, 8'h00, 8'h00, d, cr), '0);
    m_sp = (m_sp + 255) % 256;
    ram[m_sbs * 256 + m_sp] = v;
    stk.push_front(v);
    check(sp_w, m_sp, "pointer after push");
  endtask

  task automatic pop(input logic cr);
    int v;
    v = stk.pop_front();
    issue(mk(OP_POP, 4'h0, 8'h00, 8'h00, 8'h00, cr), '0);
    m_sp = (m_sp + 1) % 256;
    check(sp_w, m_sp, "pointer after pop");
    if (cr) begin
      check({mbe_w, rbe_w}, v, "flags restored");
    end else begin
      check(pop_w[3:0], v, "popped nibble");
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [11:0] da [5];
    int ks [5];
    logic [11:0] ra;
    da = '{12'h1a0, 12'h1fc, 12'h1fe, 12'h1be, 12'h1ff};
    ks = '{0, 1, 2, 3, 0};
    repeat (5) @(posedge mclk_in);
    check(pc_w, 0, "pc held in reset");
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    check(pc_w, 15'h253a, "reset start");
    check({mbe_w, rbe_w}, 2'b11, "reset enables");
    m_mbe = 1;
    m_rbe = 1;
    // stack in every bank: zero pointer pushes to the bank top, pops unwind in reverse
    for (int b = 0; b < 4; b++) begin
      wr_mem(STACK_BANK_ADDR, {4'h0, 2'b11, b[1:0]}, 1'b0);
      m_sbs = b;
      check(sbs_w, b, "stack bank upper bits zero");
      wr_mem(STACK_PTR_ADDR, 8'h00, 1'b1);
      m_sp = 0;
      check(sp_w, 0, "pointer written");
      push(rnd(), 1'b0);
      rd_mem({2'b00, b[1:0], 8'hff}, 1'b0);
      push(rnd(), 1'b0);
      pop(1'b0);
      pop(1'b0);
    end
    r8 = rnd();
    wr_mem(STACK_PTR_ADDR, r8, 1'b1);
    m_sp = r8;
    check(sp_w, r8, "pointer random write");
    issue('0, mkr(1'b0, 1'b1, 1'b1, STACK_PTR_ADDR, 8'h00));
    check(rdata_w, r8, "pointer read back");
    issue('0, mkr(1'b0, 1'b1, 1'b0, STACK_BANK_ADDR, 8'h00));
    check(rdata_w, m_sbs, "bank select read back");
    // vectors on every entry, then the active bank for every select value
    for (int i = 0; i < 7; i++) begin
      vector(i[3:0], rnd(), rnd());
      for (int s = 0; s < 4; s++) begin
        @(posedge mclk_in);
        reg_bank_select_field_in <= s[1:0];
        repeat (2) @(posedge mclk_in);
        #1;
        check(bank_w, m_rbe ? s : 0, "active bank");
      end
    end
    vector(4'h0, 8'h80, 8'h10);
    @(posedge mclk_in);
    #1;
    check(bank_w, 0, "bank forced to zero");
    // call saves only the two enables; a later vector changes them, return brings them back
    vector(4'h1, 8'hff, 8'hff);
    push(8'h00, 1'b1);
    vector(4'h2, 8'h00, 8'h01);
    pop(1'b1);
    for (int i = 0; i < 4; i++) begin
      r8 = rnd();
      issue(mk(i[0] ? OP_BR_XA : OP_BR_DE, 4'h0, r8, ~r8, 8'h00, 1'b0), '0);
      m_pc = (m_pc & 32'h7f00) + (i[0] ? r8[7:4] * 16 + (~r8 >> 4 & 15) : r8[3:0] * 16 + (~r8 & 15));
      check(pc_w, m_pc, "low byte branch");
    end
    for (int i = 0; i < 16; i++) begin
      issue(mk(OP_TABLE, i[3:0], 8'h00, 8'h00, 8'h00, 1'b0), '0);
      check(fetch_w, TABLE_BASE + 4 * i, "table fetch");
    end
    // byte round trips, register area included, and the display area decodes
    wr_mem(REG_AREA_BASE & 12'h3ff, rnd(), 1'b1);
    rd_mem(REG_AREA_BASE & 12'h3ff, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r8 = rnd();
      ra = {2'b00, r8[1:0], rnd() & 8'hfe};
      wr_mem(ra, r8, 1'b1);
      rd_mem(ra, 1'b1);
    end
    for (int i = 0; i < 5; i++) begin
      wr_mem(da[i], rnd(), 1'b0);
      check(disp_w, 1'b1, "display write seen");
      check(digit_w, i == 4, "digit port write");
      if (i < 4) begin
        check(ks_w, ks[i], "key scan decode");
      end
    end
    print_verdict();
  end
endmodule
